// >>> rtl/ubr_baud_gen.sv
// Purpose: uart bit-rate generator, one bit tick per direction
// Assumes: ref_clk is the pll core clock; timer 1 runs whenever it sources the rate
// Notes:   ticks mark bit boundaries; the shift logic consumes them
`timescale 1ns/1ps
`default_nettype none

module ubr_baud_gen (
   input  wire logic                        ref_clk,       // pll core clock
   input  wire logic                        sys_rst,       // synchronous reset, high
   input  wire logic [ubr_pkg::ADDR_W-1:0]  reg_addr,      // register offset
   input  wire logic [ubr_pkg::DATA_W-1:0]  reg_wdata,     // write data
   input  wire logic                        reg_wr,        // write strobe
   input  wire logic                        reg_rd,        // read strobe
   input  wire logic                        t1_ovf_ext,    // timer 1 overflow, non auto-reload
   output logic [ubr_pkg::DATA_W-1:0]       reg_rdata,     // read data, cycle after strobe
   output logic                             tx_bit_tick,   // transmit bit pulse
   output logic                             rx_bit_tick    // receive bit pulse
);

   // configuration registers
   logic                 baud_en_r, baud_en_nxt;
   logic [2:0]           pre_r, pre_nxt;
   logic [7:0]           frac_r, frac_nxt;
   logic [7:0]           pwr_r, pwr_nxt;
   logic [7:0]           timer_mode_reg_r, timer_mode_reg_nxt;
   logic [7:0]           t2ctl_r, t2ctl_nxt;
   logic [7:0]           t1rld_r, t1rld_nxt;
   logic [15:0]          t2rld_r, t2rld_nxt;
   logic [1:0]           umode_r, umode_nxt;
   logic [7:0]           rdata_r, rdata_nxt;
   ubr_pkg::ubr_cfg_type cfg;

   // timer state
   logic [7:0]  t1_cnt_r, t1_cnt_nxt;
   logic [15:0] t2_cnt_r, t2_cnt_nxt;
   logic        t2_half_r, t2_half_nxt;
   logic [6:0]  pre_cnt_r, pre_cnt_nxt;
   logic [8:0]  acc_r, acc_nxt;

   // output stage
   logic        tx_tick_r, tx_tick_nxt;
   logic        rx_tick_r, rx_tick_nxt;
   logic [2:0]  tx_src, rx_src;

   // internal strobes
   logic        mc_tick;
   logic        fix2_tick;
   logic        t1_auto;
   logic        t1_int_ovf;
   logic        t1_ovf;
   logic        t1_bit_tick;
   logic        t2_active;
   logic        t2_ovf;
   logic        t2_bit_tick;
   logic        pre_tick;
   logic [6:0]  pre_lim;
   logic [8:0]  frac_period;
   logic [9:0]  acc_sum;
   logic        baud_tick;
   logic [6:0]  fix2_lim;
   logic [6:0]  t1_lim;

   assign cfg.baud_timer_enable   = baud_en_r;
   assign cfg.prescale            = pre_r;
   assign cfg.baud_fraction_value = frac_r;
   assign cfg.rate_double_bit     = pwr_r[ubr_pkg::BIT_RATE_DBL];
   assign cfg.t1_mode             = timer_mode_reg_r[ubr_pkg::T1_MODE_LSB +: 2];
   assign cfg.tx_timer2_select    = t2ctl_r[ubr_pkg::BIT_TX_T2_SEL];
   assign cfg.rx_timer2_select    = t2ctl_r[ubr_pkg::BIT_RX_T2_SEL];
   assign cfg.timer1_reload_high  = t1rld_r;
   assign cfg.timer2_reload_pair  = t2rld_r;
   assign cfg.uart_mode           = umode_r;

   // register writes; reserved baud-control and uart-mode bits are not stored, the other registers keep all eight bits
   always_comb begin
      baud_en_nxt = baud_en_r;
      pre_nxt     = pre_r;
      frac_nxt    = frac_r;
      pwr_nxt     = pwr_r;
      timer_mode_reg_nxt    = timer_mode_reg_r;
      t2ctl_nxt   = t2ctl_r;
      t1rld_nxt   = t1rld_r;
      t2rld_nxt   = t2rld_r;
      umode_nxt   = umode_r;
      if (reg_wr) begin
         case (reg_addr)
            ubr_pkg::ADDR_BAUD_CTL: begin
               baud_en_nxt = reg_wdata[ubr_pkg::BIT_BAUD_EN];
               pre_nxt     = reg_wdata[ubr_pkg::PRE_MSB:0];
            end
            ubr_pkg::ADDR_BAUD_FRAC: frac_nxt = reg_wdata;
            ubr_pkg::ADDR_PWR_CTL:   pwr_nxt  = reg_wdata;
            ubr_pkg::ADDR_TMR_MODE:  timer_mode_reg_nxt = reg_wdata;
            ubr_pkg::ADDR_T2_CTL:    t2ctl_nxt = reg_wdata;
            ubr_pkg::ADDR_T1_RELOAD: t1rld_nxt = reg_wdata;
            ubr_pkg::ADDR_T2_RLD_LO: t2rld_nxt = {t2rld_r[15:8], reg_wdata};
            ubr_pkg::ADDR_T2_RLD_HI: t2rld_nxt = {reg_wdata, t2rld_r[7:0]};
            ubr_pkg::ADDR_UART_MODE: umode_nxt = reg_wdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_comb begin
      rdata_nxt = '0;
      if (reg_rd) begin
         case (reg_addr)
            ubr_pkg::ADDR_BAUD_CTL:
               rdata_nxt = {baud_en_r, 4'h0, pre_r} & ubr_pkg::BAUD_CTL_MASK;
            ubr_pkg::ADDR_BAUD_FRAC: rdata_nxt = frac_r;
            ubr_pkg::ADDR_PWR_CTL:   rdata_nxt = pwr_r;
            ubr_pkg::ADDR_TMR_MODE:  rdata_nxt = timer_mode_reg_r;
            ubr_pkg::ADDR_T2_CTL:    rdata_nxt = t2ctl_r;
            ubr_pkg::ADDR_T1_RELOAD: rdata_nxt = t1rld_r;
            ubr_pkg::ADDR_T2_RLD_LO: rdata_nxt = t2rld_r[7:0];
            ubr_pkg::ADDR_T2_RLD_HI: rdata_nxt = t2rld_r[15:8];
            ubr_pkg::ADDR_UART_MODE: rdata_nxt = {6'h00, umode_r};
            ubr_pkg::ADDR_STATUS:    rdata_nxt = {1'b0, rx_src, 1'b0, tx_src};
            default:                 rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         baud_en_r <= 1'b0;
         pre_r     <= '0;
         frac_r    <= '0;
         pwr_r     <= '0;
         timer_mode_reg_r    <= '0;
         t2ctl_r   <= '0;
         t1rld_r   <= '0;
         t2rld_r   <= '0;
         umode_r   <= ubr_pkg::UMODE_SHIFT;
         rdata_r   <= '0;
      end else begin
         baud_en_r <= baud_en_nxt;
         pre_r     <= pre_nxt;
         frac_r    <= frac_nxt;
         pwr_r     <= pwr_nxt;
         timer_mode_reg_r    <= timer_mode_reg_nxt;
         t2ctl_r   <= t2ctl_nxt;
         t1rld_r   <= t1rld_nxt;
         t2rld_r   <= t2rld_nxt;
         umode_r   <= umode_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // machine cycle: twelve core clocks, also the mode 0 bit clock
   ubr_tick_div #(.CNT_W(ubr_pkg::DIV_W)) u_machine (
      .clk   (ref_clk),
      .rst   (sys_rst),
      .step  (1'b1),
      .limit (ubr_pkg::MACHINE_DIV),
      .tick  (mc_tick)
   );

   // mode 2 fixed rate
   assign fix2_lim = cfg.rate_double_bit ? ubr_pkg::FIX_DIV_FAST
                                         : ubr_pkg::FIX_DIV_SLOW;

   ubr_tick_div #(.CNT_W(ubr_pkg::DIV_W)) u_fixed2 (
      .clk   (ref_clk),
      .rst   (sys_rst),
      .step  (1'b1),
      .limit (fix2_lim),
      .tick  (fix2_tick)
   );

   // timer 1: internal 8-bit auto-reload, otherwise the outside overflow
   assign t1_auto    = (cfg.t1_mode == ubr_pkg::T1_AUTO_RELOAD);
   assign t1_int_ovf = t1_auto && mc_tick && (t1_cnt_r == ubr_pkg::T1_TOP);
   assign t1_ovf     = t1_auto ? t1_int_ovf : t1_ovf_ext;

   always_comb begin
      t1_cnt_nxt = t1_cnt_r;
      if (t1_auto && mc_tick) begin
         t1_cnt_nxt = t1_int_ovf ? cfg.timer1_reload_high
                                 : 8'(t1_cnt_r + 8'h01);
      end
   end

   assign t1_lim = cfg.rate_double_bit ? ubr_pkg::T1_OVF_FAST
                                       : ubr_pkg::T1_OVF_SLOW;

   // one divider serves both directions; they share one rate and phase
   ubr_tick_div #(.CNT_W(ubr_pkg::DIV_W)) u_t1_bit (
      .clk   (ref_clk),
      .rst   (sys_rst),
      .step  (t1_ovf),
      .limit (t1_lim),
      .tick  (t1_bit_tick)
   );

   // timer 2 counts every other core clock in rate mode; idle it parks at reload
   assign t2_active = !cfg.baud_timer_enable &&
                      (cfg.tx_timer2_select || cfg.rx_timer2_select);
   assign t2_ovf    = t2_active && t2_half_r && (t2_cnt_r == ubr_pkg::T2_TOP);

   always_comb begin
      t2_cnt_nxt  = cfg.timer2_reload_pair;
      t2_half_nxt = 1'b0;
      if (t2_active) begin
         t2_cnt_nxt  = t2_cnt_r;
         t2_half_nxt = !t2_half_r;
         if (t2_half_r) begin
            t2_cnt_nxt = t2_ovf ? cfg.timer2_reload_pair
                                : 16'(t2_cnt_r + 16'h0001);
         end
      end
   end

   ubr_tick_div #(.CNT_W(ubr_pkg::DIV_W)) u_t2_bit (
      .clk   (ref_clk),
      .rst   (sys_rst),
      .step  (t2_ovf),
      .limit (ubr_pkg::T2_OVF_PER_BIT),
      .tick  (t2_bit_tick)
   );

   // baud timer: binary prescaler then fractional accumulator;
   // adding two per prescaled tick keeps the odd half-periods exact
   assign pre_lim     = 7'((8'h01 << cfg.prescale) - 8'h01);
   assign pre_tick    = cfg.baud_timer_enable && (pre_cnt_r >= pre_lim);
   assign frac_period = {1'b0, cfg.baud_fraction_value} + ubr_pkg::FRAC_OFFSET;
   assign acc_sum     = {1'b0, acc_r} + ubr_pkg::FRAC_STEP;
   assign baud_tick   = pre_tick && (acc_sum >= {1'b0, frac_period});

   always_comb begin
      pre_cnt_nxt = '0;
      acc_nxt     = '0;
      if (cfg.baud_timer_enable) begin
         pre_cnt_nxt = pre_tick ? 7'h00 : 7'(pre_cnt_r + 7'h01);
         acc_nxt     = acc_r;
         if (pre_tick) begin
            acc_nxt = baud_tick ? 9'(acc_sum - {1'b0, frac_period})
                                : acc_sum[8:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         t1_cnt_r  <= '0;
         t2_cnt_r  <= '0;
         t2_half_r <= 1'b0;
         pre_cnt_r <= '0;
         acc_r     <= '0;
      end else begin
         t1_cnt_r  <= t1_cnt_nxt;
         t2_cnt_r  <= t2_cnt_nxt;
         t2_half_r <= t2_half_nxt;
         pre_cnt_r <= pre_cnt_nxt;
         acc_r     <= acc_nxt;
      end
   end

   // source choice per direction
   always_comb begin
      tx_src = ubr_pkg::SRC_FIXED_12;
      rx_src = ubr_pkg::SRC_FIXED_12;
      if (cfg.baud_timer_enable) begin
         tx_src = ubr_pkg::SRC_BAUD_TMR;
         rx_src = ubr_pkg::SRC_BAUD_TMR;
      end else begin
         case (cfg.uart_mode)
            ubr_pkg::UMODE_SHIFT: begin
               tx_src = ubr_pkg::SRC_FIXED_12;
               rx_src = ubr_pkg::SRC_FIXED_12;
            end
            ubr_pkg::UMODE_9_FIX: begin
               tx_src = ubr_pkg::SRC_FIXED_2;
               rx_src = ubr_pkg::SRC_FIXED_2;
            end
            ubr_pkg::UMODE_8_VAR, ubr_pkg::UMODE_9_VAR: begin
               tx_src = cfg.tx_timer2_select ? ubr_pkg::SRC_TIMER2
                                             : ubr_pkg::SRC_TIMER1;
               rx_src = cfg.rx_timer2_select ? ubr_pkg::SRC_TIMER2
                                             : ubr_pkg::SRC_TIMER1;
            end
            default: begin
            end
         endcase
      end
   end

   function automatic logic pick_tick(input logic [2:0] src,
                                      input logic       t12,
                                      input logic       t2f,
                                      input logic       tt1,
                                      input logic       tt2,
                                      input logic       tb);
      logic r;
      r = 1'b0;
      case (src)
         ubr_pkg::SRC_FIXED_12: r = t12;
         ubr_pkg::SRC_FIXED_2:  r = t2f;
         ubr_pkg::SRC_TIMER1:   r = tt1;
         ubr_pkg::SRC_TIMER2:   r = tt2;
         ubr_pkg::SRC_BAUD_TMR: r = tb;
         default:               r = 1'b0;
      endcase
      return r;
   endfunction

   always_comb begin
      tx_tick_nxt = pick_tick(tx_src, mc_tick, fix2_tick, t1_bit_tick,
                              t2_bit_tick, baud_tick);
      rx_tick_nxt = pick_tick(rx_src, mc_tick, fix2_tick, t1_bit_tick,
                              t2_bit_tick, baud_tick);
   end

   // registered so every output leaves straight from a flop
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_tick_r <= 1'b0;
         rx_tick_r <= 1'b0;
      end else begin
         tx_tick_r <= tx_tick_nxt;
         rx_tick_r <= rx_tick_nxt;
      end
   end

   // timer 1 interrupt handling is the software's job and not seen here
   assign tx_bit_tick = tx_tick_r;
   assign rx_bit_tick = rx_tick_r;
   assign reg_rdata   = rdata_r;

endmodule // ubr_baud_gen

`default_nettype wire

// >>> rtl/ubr_pkg.sv
// Purpose: constants, register map and config carrier for the uart bit-rate generator
// Assumes: ref_clk is the pll core clock; 8-bit registers on a plain strobe port
// Notes:   all offsets and field positions used by the rtl live here

package ubr_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [3:0] ADDR_BAUD_CTL   = 4'h0;
   localparam logic [3:0] ADDR_BAUD_FRAC  = 4'h1;
   localparam logic [3:0] ADDR_PWR_CTL    = 4'h2;
   localparam logic [3:0] ADDR_TMR_MODE   = 4'h3;
   localparam logic [3:0] ADDR_T2_CTL     = 4'h4;
   localparam logic [3:0] ADDR_T1_RELOAD  = 4'h5;
   localparam logic [3:0] ADDR_T2_RLD_LO  = 4'h6;
   localparam logic [3:0] ADDR_T2_RLD_HI  = 4'h7;
   localparam logic [3:0] ADDR_UART_MODE  = 4'h8;
   localparam logic [3:0] ADDR_STATUS     = 4'h9;

   // field positions
   localparam int unsigned BIT_BAUD_EN    = 7;
   localparam int unsigned PRE_MSB        = 2;
   localparam int unsigned BIT_RATE_DBL   = 7;
   localparam int unsigned BIT_RX_T2_SEL  = 5;
   localparam int unsigned BIT_TX_T2_SEL  = 4;
   localparam int unsigned T1_MODE_LSB    = 4;
   localparam int unsigned STAT_RX_LSB    = 4;
   localparam logic [7:0]  BAUD_CTL_MASK  = 8'h87;

   // timer 1 running mode field value for 8-bit auto-reload
   localparam logic [1:0] T1_AUTO_RELOAD = 2'h2;

   // uart modes
   localparam logic [1:0] UMODE_SHIFT   = 2'h0;
   localparam logic [1:0] UMODE_8_VAR   = 2'h1;
   localparam logic [1:0] UMODE_9_FIX   = 2'h2;
   localparam logic [1:0] UMODE_9_VAR   = 2'h3;

   // divider figures
   localparam int unsigned DIV_W        = 7;
   localparam logic [6:0] MACHINE_DIV   = 7'h0C;
   localparam logic [6:0] FIX_DIV_SLOW  = 7'h40;
   localparam logic [6:0] FIX_DIV_FAST  = 7'h20;
   localparam logic [6:0] T1_OVF_SLOW   = 7'h20;
   localparam logic [6:0] T1_OVF_FAST   = 7'h10;
   localparam logic [6:0] T2_OVF_PER_BIT = 7'h10;
   localparam logic [8:0] FRAC_OFFSET   = 9'h040;
   localparam logic [9:0] FRAC_STEP     = 10'h002;
   localparam logic [7:0] T1_TOP        = 8'hFF;
   localparam logic [15:0] T2_TOP       = 16'hFFFF;

   // source codes shown in the status register
   localparam logic [2:0] SRC_FIXED_12  = 3'h0;
   localparam logic [2:0] SRC_FIXED_2   = 3'h1;
   localparam logic [2:0] SRC_TIMER1    = 3'h2;
   localparam logic [2:0] SRC_TIMER2    = 3'h3;
   localparam logic [2:0] SRC_BAUD_TMR  = 3'h4;

   typedef struct packed {
      logic        baud_timer_enable;
      logic [2:0]  prescale;
      logic [7:0]  baud_fraction_value;
      logic        rate_double_bit;
      logic [1:0]  t1_mode;
      logic        tx_timer2_select;
      logic        rx_timer2_select;
      logic [7:0]  timer1_reload_high;
      logic [15:0] timer2_reload_pair;
      logic [1:0]  uart_mode;
   } ubr_cfg_type;

endpackage

// >>> rtl/ubr_tick_div.sv
// Purpose: counts input steps and fires one pulse every limit steps
// Assumes: limit is at least one; a limit change takes effect at once against the running count
// Notes:   output is combinational, the top registers it
`timescale 1ns/1ps
`default_nettype none

module ubr_tick_div #(
   parameter int unsigned CNT_W = 7
) (
   input  wire logic             clk,    // core clock
   input  wire logic             rst,    // synchronous reset, high
   input  wire logic             step,   // one count per high cycle
   input  wire logic [CNT_W-1:0] limit,  // steps per output pulse
   output logic                  tick    // pulse on the limit-th step
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             at_end;

   // >= guards against a limit lowered below the running count
   assign at_end = (cnt_r >= CNT_W'(limit - CNT_W'(1)));
   assign tick   = step && at_end;

   always_comb begin
      cnt_nxt = cnt_r;
      if (step) begin
         cnt_nxt = at_end ? '0 : CNT_W'(cnt_r + CNT_W'(1));
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule // ubr_tick_div

`default_nettype wire

// >>> verif/test_ubr_baud_gen.sv
// Purpose: self-checking bench for the uart bit-rate generator
// Assumes: offsets and status codes as in ubr_pkg
// Notes:   timer 2 parks at its reload value while idle, so it starts fast
`timescale 1ns/1ps
`default_nettype none
module test_ubr_baud_gen;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        t1_ovf_ext = 1'b0;
   logic        ext_on = 1'b0;
   logic [1:0]  ext_cnt = 2'h0;
   logic [7:0]  reg_rdata;
   logic        tx_bit_tick;
   logic        rx_bit_tick;
   logic [31:0] seed = 32'h00000059;
   logic [7:0]  rv;
   logic [3:0]  rw_addr [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   int          miscompares = 0;
   int          checks = 0;
   ubr_baud_gen i_dut (
      .ref_clk     (ref_clk),
      .sys_rst     (sys_rst),
      .reg_addr    (reg_addr),
      .reg_wdata   (reg_wdata),
      .reg_wr      (reg_wr),
      .reg_rd      (reg_rd),
      .t1_ovf_ext  (t1_ovf_ext),
      .reg_rdata   (reg_rdata),
      .tx_bit_tick (tx_bit_tick),
      .rx_bit_tick (rx_bit_tick)
   );
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // overflow every fourth clock keeps external-source periods short
   always @(posedge ref_clk) begin
      ext_cnt <= ext_cnt + 2'h1;
      t1_ovf_ext <= ext_on && ext_cnt == 2'h3;
   end
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic int t1_per(input logic [7:0] rl, input logic dbl);
      return 12 * (256 - int'(rl)) * (dbl ? 16 : 32);
   endfunction
   function automatic int t2_per(input logic [15:0] rl);
      return 32 * (65536 - int'(rl));
   endfunction
   function automatic int bd_per2(input logic [2:0] pre, input logic [7:0] fr);
      return (1 << pre) * (int'(fr) + 64);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %0h exp %0h", $time, w, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string w);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, e, w);
   endtask
   // cycles across nper periods after skipping skip ticks
   task automatic per(input bit rx, input int skip, input int nper, input int e, input string w);
      int k;
      int c;
      int cyc;
      k = 0;
      c = 0;
      cyc = 0;
      while (k < skip + nper && c < 20000) begin
         @(negedge ref_clk);
         c++;
         if (k >= skip) cyc++;
         if ((rx ? rx_bit_tick : tx_bit_tick) === 1'b1) k++;
      end
      chk(cyc, e, w);
   endtask
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      // about twice the expected run of some 40000 cycles
      #640000;
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 16; a++) rdc(4'(a), 8'h00, "reset value");
      foreach (rw_addr[i]) begin
         rv = rnd();
         wr(rw_addr[i], rv);
         rdc(rw_addr[i], (i == 0) ? (rv & 8'h87) : (i == 8) ? (rv & 8'h03) : rv, "readback");
      end
      wr(4'h0, 8'h00);
      wr(4'h4, 8'h00);
      wr(4'h8, 8'h00);
      wr(4'hF, 8'hFF);
      rdc(4'hF, 8'h00, "unmapped");
      wr(4'h9, 8'hFF);
      rdc(4'h9, 8'h00, "status read-only");
      $display("test registers done");
      per(0, 1, 4, 48, "mode0 tx");
      per(1, 1, 4, 48, "mode0 rx");
      wr(4'h8, 8'h02);
      wr(4'h2, 8'h00);
      per(0, 2, 2, 128, "mode2 slow");
      wr(4'h2, 8'h80);
      per(1, 2, 2, 64, "mode2 fast");
      rdc(4'h9, 8'h11, "status mode2");
      $display("test fixed modes done");
      wr(4'h8, 8'h01);
      wr(4'h3, 8'h20); // rate timer runs with no interrupt reload
      rv = 8'hF8 | rnd();
      wr(4'h5, rv);
      per(0, 2, 1, t1_per(rv, 1'b1), "timer1 reload");
      rdc(4'h9, 8'h22, "status timer1");
      wr(4'h2, 8'h00);
      ext_on <= 1'b1;
      wr(4'h3, 8'h00);
      per(0, 2, 1, 128, "timer1 ext");
      $display("test timer1 done");
      wr(4'h6, 8'hFF);
      wr(4'h7, 8'hFF);
      wr(4'h4, 8'h10);
      per(0, 2, 2, 2 * t2_per(16'hFFFF), "timer2 tx");
      per(1, 1, 1, 128, "rx stays timer1");
      rdc(4'h9, 8'h23, "status split");
      rv = 8'hF0 | rnd();
      wr(4'h6, rv);
      per(0, 2, 1, t2_per({8'hFF, rv}), "timer2 reload");
      wr(4'h4, 8'h30);
      per(1, 2, 1, t2_per({8'hFF, rv}), "timer2 rx");
      $display("test timer2 done");
      ext_on <= 1'b0;
      wr(4'h2, 8'h80);
      wr(4'h1, 8'h00);
      for (int p = 0; p < 8; p++) begin
         wr(4'h0, {5'h1F, 3'(p)});
         per(0, 2, 1, bd_per2(3'(p), 8'h00) / 2, "baud prescale");
      end
      rdc(4'h9, 8'h44, "status baud");
      rv = rnd();
      wr(4'h0, 8'h81);
      wr(4'h1, rv);
      per(1, 2, 2, bd_per2(3'h1, rv), "baud fraction");
      wr(4'h8, 8'h02);
      wr(4'h0, 8'h00);
      per(0, 2, 1, 32, "baud off");
      $display("test baud timer done");
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rdc(4'h0, 8'h00, "control after reset");
      per(0, 1, 2, 24, "mode0 after reset");
      $display("test second reset done");
      give_verdict();
   end
endmodule // test_ubr_baud_gen
bind ubr_baud_gen ubr_baud_gen_checker i_chk (
   .ref_clk     (ref_clk),
   .sys_rst     (sys_rst),
   .reg_addr    (reg_addr),
   .reg_wdata   (reg_wdata),
   .reg_wr      (reg_wr),
   .reg_rd      (reg_rd),
   .t1_ovf_ext  (t1_ovf_ext),
   .reg_rdata   (reg_rdata),
   .tx_bit_tick (tx_bit_tick),
   .rx_bit_tick (rx_bit_tick)
);
`default_nettype wire

// >>> verif/ubr_baud_gen_checker.sv
// Purpose: port checks for the uart bit-rate generator
// Assumes: config changes only through reg_wr
// Notes:   period checks wait two ticks after any write
`timescale 1ns/1ps
`default_nettype none
module ubr_baud_gen_checker (
   input wire logic       ref_clk,     // core clock
   input wire logic       sys_rst,     // sync reset
   input wire logic [3:0] reg_addr,    // offset
   input wire logic [7:0] reg_wdata,   // write data
   input wire logic       reg_wr,      // write strobe
   input wire logic       reg_rd,      // read strobe
   input wire logic       t1_ovf_ext,  // timer 1 overflow
   input wire logic [7:0] reg_rdata,   // read data
   input wire logic       tx_bit_tick, // tx pulse
   input wire logic       rx_bit_tick  // rx pulse
);
   logic [7:0]  ctl_r;
   logic [7:0]  mode_r;
   logic [7:0]  pwr_r;
   logic [7:0]  frac_r;
   logic [15:0] gap_r;
   logic [1:0]  nt_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // first tick after a write may be cut short, so count two
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctl_r  <= 8'h00;
         mode_r <= 8'h00;
         pwr_r  <= 8'h00;
         frac_r <= 8'h00;
         gap_r  <= 16'h0000;
         nt_r   <= 2'h0;
      end else begin
         if (reg_wr && reg_addr == 4'h0) ctl_r <= reg_wdata;
         if (reg_wr && reg_addr == 4'h1) frac_r <= reg_wdata;
         if (reg_wr && reg_addr == 4'h2) pwr_r <= reg_wdata;
         if (reg_wr && reg_addr == 4'h8) mode_r <= reg_wdata;
         gap_r <= tx_bit_tick ? 16'h0001 : gap_r + 16'h0001;
         if (reg_wr) nt_r <= 2'h0;
         else if (tx_bit_tick && nt_r != 2'h3) nt_r <= nt_r + 2'h1;
      end
   end
   AST_RST_QUIET: assert property ($fell(sys_rst) |-> !tx_bit_tick && !rx_bit_tick)
      else $error("tick right after reset");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   AST_RD_UNMAPPED: assert property (reg_rd && reg_addr > 4'h9 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_CTL_READ: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == (ctl_r & 8'h87))
      else $error("control readback wrong");
   AST_TICK_PULSE: assert property (tx_bit_tick && !reg_wr |=> !tx_bit_tick)
      else $error("tx tick longer than one cycle");
   AST_MODE0_PER: assert property (tx_bit_tick && nt_r[1] && !ctl_r[7] && mode_r[1:0] == 2'h0
      |-> gap_r == 16'h000C)
      else $error("mode 0 period wrong");
   AST_MODE2_PER: assert property (tx_bit_tick && nt_r[1] && !ctl_r[7] && mode_r[1:0] == 2'h2
      |-> gap_r == (pwr_r[7] ? 16'h0020 : 16'h0040))
      else $error("mode 2 period wrong");
   AST_BAUD_PER: assert property (tx_bit_tick && nt_r[1] && ctl_r[7] && frac_r == 8'h00
      |-> gap_r == (16'h0020 << ctl_r[2:0]))
      else $error("baud timer period wrong");
   COV_MODE0: cover property (tx_bit_tick && mode_r[1:0] == 2'h0);
   COV_BAUD: cover property (tx_bit_tick && ctl_r[7]);
   COV_STATUS: cover property (reg_rd && reg_addr == 4'h9);
endmodule // ubr_baud_gen_checker
`default_nettype wire
